/* event_group.sv */
// Purpose: One status group: event latch, enable mask and summary.
// Assumes: Condition inputs are synchronous to the clock.
// Notes: Undefined bits are held at zero by the DEFINED parameter.
`timescale 1ns/1ps
`default_nettype none
module event_group import status_pkg::*; #(
	parameter logic [15:0] DEFINED = 16'hffff
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [15:0] cond_i,
	input wire logic mask_we_i,
	input wire logic [15:0] mask_wdata_i,
	input wire logic preset_i,
	input wire logic event_rd_i,
	output logic [15:0] event_o,
	output logic [15:0] mask_o,
	output logic summary_o
);
	logic [15:0] cond_q;
	logic [15:0] event_q;
	logic [15:0] mask_q;
	logic [15:0] cond_m;
	logic [15:0] rise;

	assign cond_m = cond_i & DEFINED;
	assign rise = cond_m & ~cond_q;

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			cond_q <= 16'h0000;
		end else begin
			cond_q <= cond_m;
		end
	end

	// A rise in the read cycle survives the clear, so no entry is lost.
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			event_q <= 16'h0000;
		end else if (event_rd_i) begin
			event_q <= rise;
		end else begin
			event_q <= event_q | rise;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			mask_q <= MASK_RESET;
		end else if (preset_i) begin
			mask_q <= MASK_RESET;
		end else if (mask_we_i) begin
			mask_q <= mask_wdata_i & DEFINED;
		end
	end

	assign event_o = event_q;
	assign mask_o = mask_q;
	assign summary_o = |(event_q & mask_q);
endmodule : event_group
`default_nettype wire

/* status_pkg.sv */
// Purpose: Shared constants and types for the status reporting registers.
// Assumes: Registers are reached through a simple command port, one word per access.
// Notes: Selector codes identify registers; they are not bus addresses.
package status_pkg;

	// ----------------------------------------
	// Register selectors
	// ----------------------------------------
	localparam logic [2:0] SEL_OPER_LIVE = 3'h0;
	localparam logic [2:0] SEL_OPER_EVENT = 3'h1;
	localparam logic [2:0] SEL_OPER_MASK = 3'h2;
	localparam logic [2:0] SEL_QUES_LIVE = 3'h3;
	localparam logic [2:0] SEL_QUES_EVENT = 3'h4;
	localparam logic [2:0] SEL_QUES_MASK = 3'h5;

	// ----------------------------------------
	// Field layout and reset values
	// ----------------------------------------
	localparam int REG_W = 16;
	localparam logic [15:0] OPER_DEFINED = 16'h0521;
	localparam logic [15:0] QUES_DEFINED = 16'h0008;
	localparam logic [15:0] MASK_RESET = 16'h0000;
	localparam int CAL_BIT = 0;
	localparam int TRIG_BIT = 5;
	localparam int CONSTANT_VOLTAGE_BIT = 8;
	localparam int CONSTANT_CURRENT_BIT = 10;
	localparam int OVERTEMPERATURE_BIT = 3;
	localparam int OPER_SUM_BIT = 7;
	localparam int QUES_SUM_BIT = 3;

	typedef struct packed {
		logic constant_current_flag;
		logic constant_voltage_flag;
		logic trigger_pending_flag;
		logic calibration_busy_flag;
	} oper_cond_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic preset;
		logic [2:0] sel;
		logic [15:0] wdata;
	} cmd_t;

endpackage : status_pkg

/* status_regs.sv */
// Purpose: Operation and questionable status groups with a command port.
// Assumes: One command per valid cycle; read data appears one cycle later.
// Notes: Undefined selectors read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Operation mask stores written values, defined bits.
// - Status bit 7 ORs enabled operation events.
// - Operation mask read returns stored value.
// - Operation events latch until read.
// - Operation event read returns, then clears.
// - Events set on entering a condition.
// - Preset clears both enable masks.
// - Questionable bit 3 is overtemperature only.
// - Questionable events latch since previous read.
// - Questionable event read returns, then clears.
// - Questionable condition reads live, unlatched.
// - Status bit 3 ORs enabled questionable events.
// - Questionable mask read returns stored value.
// - Operation bits 0,5,8,10; others zero.
// - Operation condition reads live, unchanged.
module status_regs import status_pkg::*; (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire oper_cond_t oper_cond_i,
	input wire logic overtemperature_flag_i,
	input wire cmd_t cmd_i,
	output logic [15:0] rdata_o,
	output logic rvalid_o,
	output logic [7:0] status_byte_o
);
	logic [15:0] oper_live;
	logic [15:0] ques_live;
	logic [15:0] oper_event;
	logic [15:0] oper_mask;
	logic [15:0] ques_event;
	logic [15:0] ques_mask;
	logic oper_sum;
	logic ques_sum;
	logic rd;
	logic [15:0] rdata_d;
	logic [15:0] rdata_q;
	logic rvalid_q;

	// ----------------------------------------
	// Live conditions
	// ----------------------------------------
	always_comb begin
		oper_live = 16'h0000;
		oper_live[CAL_BIT] = oper_cond_i.calibration_busy_flag;
		oper_live[TRIG_BIT] = oper_cond_i.trigger_pending_flag;
		oper_live[CONSTANT_VOLTAGE_BIT] = oper_cond_i.constant_voltage_flag;
		oper_live[CONSTANT_CURRENT_BIT] = oper_cond_i.constant_current_flag;
		ques_live = 16'h0000;
		ques_live[OVERTEMPERATURE_BIT] = overtemperature_flag_i;
	end

	assign rd = cmd_i.valid && !cmd_i.write && !cmd_i.preset;

	// ----------------------------------------
	// Groups
	// ----------------------------------------
	event_group #(.DEFINED(OPER_DEFINED)) u_oper (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.cond_i(oper_live),
		.mask_we_i(cmd_i.valid && cmd_i.write && cmd_i.sel == SEL_OPER_MASK),
		.mask_wdata_i(cmd_i.wdata),
		.preset_i(cmd_i.valid && cmd_i.preset),
		.event_rd_i(rd && cmd_i.sel == SEL_OPER_EVENT),
		.event_o(oper_event),
		.mask_o(oper_mask),
		.summary_o(oper_sum)
	);

	event_group #(.DEFINED(QUES_DEFINED)) u_ques (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.cond_i(ques_live),
		.mask_we_i(cmd_i.valid && cmd_i.write && cmd_i.sel == SEL_QUES_MASK),
		.mask_wdata_i(cmd_i.wdata),
		.preset_i(cmd_i.valid && cmd_i.preset),
		.event_rd_i(rd && cmd_i.sel == SEL_QUES_EVENT),
		.event_o(ques_event),
		.mask_o(ques_mask),
		.summary_o(ques_sum)
	);

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	// Event reads return the value held before the clear takes effect.
	always_comb begin
		case (cmd_i.sel)
			SEL_OPER_LIVE: rdata_d = oper_live;
			SEL_OPER_EVENT: rdata_d = oper_event;
			SEL_OPER_MASK: rdata_d = oper_mask;
			SEL_QUES_LIVE: rdata_d = ques_live;
			SEL_QUES_EVENT: rdata_d = ques_event;
			SEL_QUES_MASK: rdata_d = ques_mask;
			default: rdata_d = 16'h0000;
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			rdata_q <= 16'h0000;
		end else if (rd) begin
			rdata_q <= rdata_d;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= rd;
		end
	end

	assign rdata_o = rdata_q;
	assign rvalid_o = rvalid_q;

	always_comb begin
		status_byte_o = 8'h00;
		status_byte_o[OPER_SUM_BIT] = oper_sum;
		status_byte_o[QUES_SUM_BIT] = ques_sum;
	end
endmodule : status_regs
`default_nettype wire

/* status_regs_sva.sv */
// Purpose: Port checker for status_regs.
// Assumes: One clock, synchronous reset.
// Notes: Event latches are judged through reads.
`timescale 1ns/1ps
`default_nettype none
module status_regs_chk import status_pkg::*; (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire oper_cond_t oper_cond_i,
	input wire logic overtemperature_flag_i,
	input wire cmd_t cmd_i,
	input wire logic [15:0] rdata_o,
	input wire logic rvalid_o,
	input wire logic [7:0] status_byte_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	logic rd_w;
	logic [15:0] op_w;
	assign rd_w = cmd_i.valid && !cmd_i.write && !cmd_i.preset;
	assign op_w = {5'h00, oper_cond_i[3], 1'b0, oper_cond_i[2], 2'h0, oper_cond_i[1], 4'h0,
		oper_cond_i[0]};
	AST_RVALID: assert property (rd_w |=> rvalid_o) else $error("read unanswered");
	AST_NORV: assert property (!rd_w |=> !rvalid_o) else $error("stray answer");
	AST_OLIVE: assert property (rd_w && cmd_i.sel == SEL_OPER_LIVE |=>
		rdata_o == $past(op_w)) else $error("bad op condition");
	AST_QLIVE: assert property (rd_w && cmd_i.sel == SEL_QUES_LIVE |=>
		rdata_o == {12'h000, $past(overtemperature_flag_i), 3'h0}) else $error("bad q cond");
	AST_OEVT: assert property (rd_w && cmd_i.sel == SEL_OPER_EVENT |=>
		(rdata_o & ~OPER_DEFINED) == 16'h0000) else $error("op event spare bit");
	AST_QEVT: assert property (rd_w && cmd_i.sel == SEL_QUES_EVENT |=>
		(rdata_o & ~QUES_DEFINED) == 16'h0000) else $error("q event spare bit");
	AST_PRESET: assert property (cmd_i.valid && cmd_i.preset |=> status_byte_o == 8'h00)
		else $error("summary after preset");
	AST_MASK: assert property (cmd_i.valid && cmd_i.write && !cmd_i.preset &&
		cmd_i.sel == SEL_OPER_MASK ##3 (rd_w && cmd_i.sel == SEL_OPER_MASK) |=>
		rdata_o == ($past(cmd_i.wdata, 4) & OPER_DEFINED)) else $error("op mask readback");
	AST_SPARE: assert property ({status_byte_o[6:4], status_byte_o[2:0]} == 6'h00)
		else $error("status spare bit");
endmodule : status_regs_chk
`default_nettype wire

/* status_regs_test.sv */
// Purpose: Self-checking bench for status_regs.
// Assumes: Commands change 1 ns after the rising edge.
// Notes: Expected words come from the bit layout.
`timescale 1ns/1ps
`default_nettype none
module status_regs_test import status_pkg::*;;
	logic core_clk_i = 1'b0;
	logic rst_i = 1'b1;
	oper_cond_t oper_cond_i = '0;
	logic overtemperature_flag_i = 1'b0;
	cmd_t cmd_i = '0;
	logic [15:0] rdata_o;
	logic rvalid_o;
	logic [7:0] status_byte_o;
	int err_total = 0;
	int checks = 0;
	int cyc = 0;
	status_regs dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .oper_cond_i(oper_cond_i),
		.overtemperature_flag_i(overtemperature_flag_i), .cmd_i(cmd_i), .rdata_o(rdata_o),
		.rvalid_o(rvalid_o), .status_byte_o(status_byte_o));
	initial begin
		forever #10 core_clk_i = ~core_clk_i;
	end
	task automatic conclude();
		$display("checks %0d errors %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : conclude
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("Error %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic send(input logic p, input logic w, input logic [2:0] s, input logic [15:0] d);
		@(posedge core_clk_i);
		#1 cmd_i = '{1'b1, w, p, s, d};
		@(posedge core_clk_i);
		#1 cmd_i.valid = 1'b0;
		@(posedge core_clk_i);
		#1;
	endtask : send
	task automatic rd(input logic [2:0] s, input logic [15:0] exp);
		@(posedge core_clk_i);
		#1 cmd_i = '{1'b1, 1'b0, 1'b0, s, 16'h0000};
		@(posedge core_clk_i);
		#1 cmd_i.valid = 1'b0;
		chk({15'h0000, rvalid_o}, 16'h0001);
		chk(rdata_o, exp);
		@(posedge core_clk_i);
		#1 chk({15'h0000, rvalid_o}, 16'h0000);
	endtask : rd
	always @(posedge core_clk_i) begin
		cyc++;
		if (cyc == 500) begin
			err_total++;
			conclude();
		end
	end
	initial begin
		repeat (5) @(posedge core_clk_i);
		#1 rst_i = 1'b0;
		rd(SEL_OPER_MASK, MASK_RESET);
		send(1'b0, 1'b1, SEL_OPER_MASK, 16'hffff);
		rd(SEL_OPER_MASK, 16'h0521);
		send(1'b0, 1'b1, SEL_QUES_MASK, 16'hffff);
		rd(SEL_QUES_MASK, 16'h0008);
		send(1'b0, 1'b1, 3'h6, 16'hffff);
		rd(3'h6, 16'h0000);
		$display("test masks done");
		oper_cond_i = 4'b0110;
		rd(SEL_OPER_LIVE, 16'h0120);
		oper_cond_i = 4'b1110;
		rd(SEL_OPER_LIVE, 16'h0520);
		chk({8'h00, status_byte_o}, 16'h0080);
		rd(SEL_OPER_EVENT, 16'h0520);
		rd(SEL_OPER_EVENT, 16'h0000);
		chk({8'h00, status_byte_o}, 16'h0000);
		oper_cond_i = 4'b0111;
		rd(SEL_OPER_EVENT, 16'h0001);
		overtemperature_flag_i = 1'b1;
		rd(SEL_QUES_LIVE, 16'h0008);
		chk({8'h00, status_byte_o}, 16'h0008);
		rd(SEL_QUES_EVENT, 16'h0008);
		rd(SEL_QUES_EVENT, 16'h0000);
		rd(SEL_QUES_LIVE, 16'h0008);
		overtemperature_flag_i = 1'b0;
		rd(SEL_QUES_EVENT, 16'h0000);
		// The condition rises in the very cycle the read is taken.
		fork
			rd(SEL_QUES_EVENT, 16'h0000);
			begin
				@(posedge core_clk_i);
				#1 overtemperature_flag_i = 1'b1;
			end
		join
		rd(SEL_QUES_EVENT, 16'h0008);
		send(1'b1, 1'b0, 3'h0, 16'h0000);
		rd(SEL_OPER_MASK, 16'h0000);
		rd(SEL_QUES_MASK, 16'h0000);
		$display("test events done");
		conclude();
	end
endmodule : status_regs_test
bind status_regs status_regs_chk chk_i (.core_clk_i(core_clk_i), .rst_i(rst_i),
	.oper_cond_i(oper_cond_i), .overtemperature_flag_i(overtemperature_flag_i),
	.cmd_i(cmd_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .status_byte_o(status_byte_o));
`default_nettype wire
